// >>> src/opcode_decoder_transfer_arith.sv
`timescale 1ns/1ps
// Decoder for transfer and add-with-carry instructions fed from the prefetch queue
// What this block does
// - Byte D7 alone decodes as table_translate_byte into low_accumulator_byte, one byte long.
// - Byte C5 plus addressing byte loads far pointer into register and data segment.
// - Byte C4 plus addressing byte loads far pointer into register and extra segment.
// - Add-with-carry: 000100dw with addressing byte, or 0001010w with one/two data bytes.
// - Byte 8C with addressing bit 5 clear copies selected segment register out.
// - Byte 37 alone decodes as unpacked_decimal_add_fixup on the accumulator.
// - Byte 27 alone decodes as packed_decimal_add_fixup on the accumulator.
module opcode_decoder_transfer_arith (
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  sys_rst,
    // Prefetch queue window, byte 0 is the first byte
    input  wire logic                  qValid,
    input  wire logic [7:0]            qByte0,
    input  wire logic [7:0]            qByte1,
    input  wire logic [2:0]            qCount,
    output logic                       qConsume,
    output logic      [2:0]            qAdvance,
    // Decoded operation to the datapath
    input  wire logic                  exReady,
    output logic                       decValid,
    output opdec_pkg::op_kind_e        decKind,
    output logic      [2:0]            decLength,
    output logic                       decWide,
    output logic                       decDir,
    output logic      [2:0]            decRegSel,
    output logic      [7:0]            decModrm
);
    // First byte classification
    wire logic isXlat   = (qByte0 == opdec_pkg::OP_TABLE_XLATE);
    wire logic isLds    = (qByte0 == opdec_pkg::OP_LOAD_PTR_DS);
    wire logic isLes    = (qByte0 == opdec_pkg::OP_LOAD_PTR_ES);
    wire logic isAdcRm  = (qByte0[7:2] == opdec_pkg::OP_ADC_RM_TOP);
    wire logic isAdcAcc = (qByte0[7:1] == opdec_pkg::OP_ADC_ACC_TOP);
    wire logic isSegOut = (qByte0 == opdec_pkg::OP_SEG_TO_RM);
    wire logic isUnpack = (qByte0 == opdec_pkg::OP_UNPACK_FIX);
    wire logic isPack   = (qByte0 == opdec_pkg::OP_PACK_FIX);
    wire logic wideFlag = qByte0[opdec_pkg::BIT_LEN_FLAG];
    wire logic segOk    = ~qByte1[opdec_pkg::BIT_SEG_ZERO];
    wire logic hasModrm = isLds | isLes | isAdcRm | isSegOut;

    logic [1:0] dispBytes;

    opdec_modrm_len u_modrm_len (
        .modrmByte (qByte1),
        .dispBytes (dispBytes)
    );

    // Total length in bytes
    wire logic [2:0] modrmLen = 3'h2 + {1'b0, dispBytes};
    wire logic [2:0] immLen   = wideFlag ? 3'h3 : 3'h2;
    wire logic [2:0] lenNow   = hasModrm ? modrmLen :
                                isAdcAcc ? immLen : 3'h1;

    // Unknown opcodes consume one byte so the fetch stream keeps moving
    wire opdec_pkg::op_kind_e kindNow =
        isXlat   ? opdec_pkg::OPK_TABLE_TRANSLATE_BYTE :
        isLds    ? opdec_pkg::OPK_LOAD_FAR_POINTER_DATA_SEG :
        isLes    ? opdec_pkg::OPK_LOAD_FAR_POINTER_EXTRA_SEG :
        isAdcRm  ? opdec_pkg::OPK_ADC_REG_RM :
        isAdcAcc ? opdec_pkg::OPK_ADC_ACC_IMM :
        (isSegOut && segOk) ? opdec_pkg::OPK_SEG_TO_RM :
        isUnpack ? opdec_pkg::OPK_UNPACKED_DECIMAL_ADD_FIXUP :
        isPack   ? opdec_pkg::OPK_PACKED_DECIMAL_ADD_FIXUP :
        opdec_pkg::OPK_ILLEGAL;

    // Wait until the whole instruction sits in the queue
    wire logic enough   = qValid && (qCount >= lenNow);
    wire logic outFree  = ~decValid | exReady;
    wire logic takeNow  = enough && outFree;

    assign qConsume = takeNow;
    assign qAdvance = takeNow ? lenNow : opdec_pkg::LEN_RESET;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            decValid <= 1'b0;
        end else if (takeNow) begin
            decValid <= 1'b1;
        end else if (exReady) begin
            decValid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            decKind   <= opdec_pkg::OPK_NONE;
            decLength <= opdec_pkg::LEN_RESET;
            decWide   <= 1'b0;
            decDir    <= 1'b0;
            decRegSel <= 3'h0;
            decModrm  <= 8'h00;
        end else if (takeNow) begin
            decKind   <= kindNow;
            decLength <= lenNow;
            decWide   <= (isAdcRm | isAdcAcc) & wideFlag;
            decDir    <= isAdcRm & qByte0[opdec_pkg::BIT_DIR_FLAG];
            decRegSel <= hasModrm ? qByte1[opdec_pkg::REG_HI:opdec_pkg::REG_LO] : 3'h0;
            decModrm  <= hasModrm ? qByte1 : 8'h00;
        end
    end


    // Decode of each first byte
    chk_table_translate_byte_one_byte: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_TABLE_XLATE)
        |=> (decKind == opdec_pkg::OPK_TABLE_TRANSLATE_BYTE && decLength == 3'h1))
        else $error("translate byte misdecoded");

    chk_lds_kind: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_LOAD_PTR_DS)
        |=> (decKind == opdec_pkg::OPK_LOAD_FAR_POINTER_DATA_SEG && decLength >= 3'h2))
        else $error("data segment pointer load misdecoded");

    chk_lds_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_LOAD_PTR_DS)
        |=> (decModrm == $past(qByte1) && decRegSel == $past(qByte1[5:3])))
        else $error("data segment pointer load fields wrong");

    chk_les_kind: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_LOAD_PTR_ES)
        |=> (decKind == opdec_pkg::OPK_LOAD_FAR_POINTER_EXTRA_SEG && decLength >= 3'h2))
        else $error("extra segment pointer load misdecoded");

    chk_les_fields: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_LOAD_PTR_ES)
        |=> (decModrm == $past(qByte1) && decRegSel == $past(qByte1[5:3])))
        else $error("extra segment pointer load fields wrong");

    chk_adc_imm_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0[7:1] == opdec_pkg::OP_ADC_ACC_TOP)
        |=> (decLength == ($past(qByte0[0]) ? 3'h3 : 3'h2)))
        else $error("add with carry immediate length wrong");

    chk_adc_acc_kind: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0[7:1] == opdec_pkg::OP_ADC_ACC_TOP)
        |=> (decKind == opdec_pkg::OPK_ADC_ACC_IMM && decWide == $past(qByte0[0]) && !decDir))
        else $error("add with carry immediate form wrong");

    chk_adc_rm_dir: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0[7:2] == opdec_pkg::OP_ADC_RM_TOP)
        |=> (decKind == opdec_pkg::OPK_ADC_REG_RM && decDir == $past(qByte0[1])))
        else $error("add with carry register form wrong");

    chk_adc_rm_wide: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0[7:2] == opdec_pkg::OP_ADC_RM_TOP)
        |=> (decWide == $past(qByte0[0]) && decModrm == $past(qByte1)))
        else $error("add with carry register width wrong");

    chk_seg_select: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_SEG_TO_RM && !qByte1[5])
        |=> (decKind == opdec_pkg::OPK_SEG_TO_RM && decRegSel == $past(qByte1[5:3])))
        else $error("segment copy misdecoded");

    chk_seg_bit_set: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_SEG_TO_RM && qByte1[5])
        |=> (decKind == opdec_pkg::OPK_ILLEGAL))
        else $error("segment copy accepted with bit five set");

    chk_unpack_fix: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_UNPACK_FIX)
        |=> (decKind == opdec_pkg::OPK_UNPACKED_DECIMAL_ADD_FIXUP && decLength == 3'h1))
        else $error("unpacked fixup misdecoded");

    chk_pack_fix: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && qByte0 == opdec_pkg::OP_PACK_FIX)
        |=> (decKind == opdec_pkg::OPK_PACKED_DECIMAL_ADD_FIXUP && decLength == 3'h1))
        else $error("packed fixup misdecoded");

    chk_one_byte_clean: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && (isXlat || isUnpack || isPack))
        |=> (decModrm == 8'h00 && decRegSel == 3'h0 && !decWide && !decDir))
        else $error("one byte instruction carries operand fields");

    // Length and queue handshake
    chk_advance_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        qConsume
        |=> (decValid && decLength == $past(qAdvance)))
        else $error("advance and reported length disagree");

    chk_refuse_short: assert property (@(posedge core_clk) disable iff (sys_rst)
        (qCount < lenNow)
        |-> (!qConsume && qAdvance == 3'h0))
        else $error("instruction taken before all bytes arrived");

    chk_advance_bound: assert property (@(posedge core_clk) disable iff (sys_rst)
        qConsume
        |-> (qAdvance != 3'h0 && qAdvance <= qCount))
        else $error("advance exceeds queue contents");

    chk_no_take_stall: assert property (@(posedge core_clk) disable iff (sys_rst)
        (decValid && !exReady)
        |-> !qConsume)
        else $error("new instruction taken while output stalled");

    chk_hold_stall: assert property (@(posedge core_clk) disable iff (sys_rst)
        (decValid && !exReady)
        |=> (decValid && $stable(decKind) && $stable(decLength)))
        else $error("decoded output changed while stalled");

    chk_drop_valid: assert property (@(posedge core_clk) disable iff (sys_rst)
        (decValid && exReady && !qConsume)
        |=> !decValid)
        else $error("decoded output not released after acceptance");

    chk_modrm_range: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && hasModrm)
        |=> (decLength >= 3'h2 && decLength <= 3'h4))
        else $error("addressing form length out of range");

    chk_reg_mode_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && hasModrm && qByte1[7:6] == 2'h3)
        |=> (decLength == 3'h2))
        else $error("register operand form length wrong");

    chk_direct_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && hasModrm && qByte1[7:6] == opdec_pkg::MOD_NO_DISP && qByte1[2:0] == opdec_pkg::RM_DIRECT)
        |=> (decLength == 3'h4))
        else $error("direct address form length wrong");

    chk_disp8_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && hasModrm && qByte1[7:6] == opdec_pkg::MOD_DISP8)
        |=> (decLength == 3'h3))
        else $error("short displacement form length wrong");

    chk_unknown_len: assert property (@(posedge core_clk) disable iff (sys_rst)
        (takeNow && !hasModrm && !isAdcAcc)
        |=> (decLength == 3'h1))
        else $error("single byte form length wrong");
endmodule

// >>> src/opdec_pkg.sv
// Shared encodings, operation codes and field positions for the opcode decoder
package opdec_pkg;
    localparam logic [7:0] OP_TABLE_XLATE   = 8'hD7;
    localparam logic [7:0] OP_LOAD_PTR_DS   = 8'hC5;
    localparam logic [7:0] OP_LOAD_PTR_ES   = 8'hC4;
    localparam logic [7:0] OP_SEG_TO_RM     = 8'h8C;
    localparam logic [7:0] OP_UNPACK_FIX    = 8'h37;
    localparam logic [7:0] OP_PACK_FIX      = 8'h27;
    localparam logic [5:0] OP_ADC_RM_TOP    = 6'h04;
    localparam logic [6:0] OP_ADC_ACC_TOP   = 7'h0A;
    localparam int         BIT_LEN_FLAG     = 0;
    localparam int         BIT_DIR_FLAG     = 1;
    localparam int         BIT_SEG_ZERO     = 5;
    localparam int         MOD_HI           = 7;
    localparam int         MOD_LO           = 6;
    localparam int         REG_HI           = 5;
    localparam int         REG_LO           = 3;
    localparam int         RM_HI            = 2;
    localparam int         RM_LO            = 0;
    localparam logic [1:0] MOD_NO_DISP      = 2'h0;
    localparam logic [1:0] MOD_DISP8        = 2'h1;
    localparam logic [1:0] MOD_DISP16       = 2'h2;
    localparam logic [2:0] RM_DIRECT        = 3'h6;
    localparam logic [2:0] LEN_RESET        = 3'h0;

    typedef enum logic [3:0] {
        OPK_NONE,
        OPK_TABLE_TRANSLATE_BYTE,
        OPK_LOAD_FAR_POINTER_DATA_SEG,
        OPK_LOAD_FAR_POINTER_EXTRA_SEG,
        OPK_ADC_REG_RM,
        OPK_ADC_ACC_IMM,
        OPK_SEG_TO_RM,
        OPK_UNPACKED_DECIMAL_ADD_FIXUP,
        OPK_PACKED_DECIMAL_ADD_FIXUP,
        OPK_ILLEGAL
    } op_kind_e;
endpackage

// >>> src/opdec_modrm_len.sv
`timescale 1ns/1ps
// Displacement length implied by an addressing byte
module opdec_modrm_len (
    // Addressing byte
    input  wire logic [7:0] modrmByte,
    // Displacement bytes that follow it
    output logic      [1:0] dispBytes
);
    wire logic [1:0] modField = modrmByte[opdec_pkg::MOD_HI:opdec_pkg::MOD_LO];
    wire logic [2:0] rmField  = modrmByte[opdec_pkg::RM_HI:opdec_pkg::RM_LO];

    // Direct address hides under mod 00 with r/m 110 and carries 16 bits
    assign dispBytes = (modField == opdec_pkg::MOD_DISP8)  ? 2'h1 :
                       (modField == opdec_pkg::MOD_DISP16) ? 2'h2 :
                       ((modField == opdec_pkg::MOD_NO_DISP) && (rmField == opdec_pkg::RM_DIRECT)) ? 2'h2 :
                       2'h0;
endmodule

// >>> verification/prefetch_queue_model.sv
`timescale 1ns/1ps
// Behavioural prefetch queue feeding instruction bytes to the decoder
module prefetch_queue_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Queue window
    input  wire logic       qConsume,
    input  wire logic [2:0] qAdvance,
    output logic            qValid,
    output logic      [7:0] qByte0,
    output logic      [7:0] qByte1,
    output logic      [2:0] qCount
);
    logic [7:0] fifo[$];
    logic [7:0] stale = 8'h00;
    always @(posedge core_clk) begin
        if (!sys_rst && qConsume === 1'b1) begin
            repeat (qAdvance) void'(fifo.pop_front());
        end
    end
    // Empty slots toggle so the decoder can never lean on a stale byte
    initial forever begin
        stale = ~stale;
        qValid = fifo.size() > 0;
        qCount = (fifo.size() > 7) ? 3'h7 : 3'(fifo.size());
        qByte0 = (fifo.size() > 0) ? fifo[0] : stale;
        qByte1 = (fifo.size() > 1) ? fifo[1] : ~stale;
        @(negedge core_clk);
    end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the transfer and add-with-carry decoder
module testbench;
    logic                core_clk, sys_rst, exReady, qConsume, qValid, decValid, decWide, decDir;
    logic [7:0]          qByte0, qByte1, decModrm;
    logic [2:0]          qCount, qAdvance, decLength, decRegSel;
    opdec_pkg::op_kind_e decKind;
    logic [7:0]          pending[$];
    logic [19:0]         notes[$];
    logic [19:0]         got;
    logic [16:0]         lfsr = 17'h174C7;
    int                  n_mismatch = 0;
    int                  n_checks = 0;
    logic [7:0]          ops[10] = '{8'hD7, 8'hC5, 8'hC4, 8'h10, 8'h14, 8'h8C, 8'h37, 8'h27, 8'hF4, 8'h12};
    opdec_pkg::op_kind_e kinds[10] = '{opdec_pkg::OPK_TABLE_TRANSLATE_BYTE, opdec_pkg::OPK_LOAD_FAR_POINTER_DATA_SEG,
        opdec_pkg::OPK_LOAD_FAR_POINTER_EXTRA_SEG, opdec_pkg::OPK_ADC_REG_RM, opdec_pkg::OPK_ADC_ACC_IMM,
        opdec_pkg::OPK_SEG_TO_RM, opdec_pkg::OPK_UNPACKED_DECIMAL_ADD_FIXUP,
        opdec_pkg::OPK_PACKED_DECIMAL_ADD_FIXUP, opdec_pkg::OPK_ILLEGAL, opdec_pkg::OPK_ADC_REG_RM};
    function automatic logic [16:0] step(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Notes the expected decode and queues the bytes of one instruction
    task automatic emit(input opdec_pkg::op_kind_e k, input logic [7:0] b0, input logic [7:0] b1);
        logic       rm, adc;
        logic [2:0] len, disp;
        rm = k inside {opdec_pkg::OPK_LOAD_FAR_POINTER_DATA_SEG, opdec_pkg::OPK_LOAD_FAR_POINTER_EXTRA_SEG,
                       opdec_pkg::OPK_ADC_REG_RM, opdec_pkg::OPK_SEG_TO_RM};
        adc = k inside {opdec_pkg::OPK_ADC_REG_RM, opdec_pkg::OPK_ADC_ACC_IMM};
        disp = (b1[7:6] == 2'h1) ? 3'h1 : (b1[7:6] == 2'h2 || (b1[7:6] == 2'h0 && b1[2:0] == 3'h6)) ? 3'h2 : 3'h0;
        len = rm ? 3'h2 + disp : (k == opdec_pkg::OPK_ADC_ACC_IMM) ? 3'h2 + 3'(b0[0]) : 3'h1;
        notes.push_back({k, len, adc & b0[0], (k == opdec_pkg::OPK_ADC_REG_RM) & b0[1], rm ? b1[5:3] : 3'h0,
                         rm ? b1 : 8'h00});
        pending.push_back(b0);
        if (len > 1) pending.push_back(b1);
        for (int i = 2; i < len; i++) pending.push_back(8'(i * 8'h35));
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    prefetch_queue_model i_pq (.core_clk, .sys_rst, .qConsume, .qAdvance, .qValid, .qByte0, .qByte1, .qCount);
    opcode_decoder_transfer_arith i_dut (.core_clk, .sys_rst, .qValid, .qByte0, .qByte1, .qCount, .qConsume,
        .qAdvance, .exReady, .decValid, .decKind, .decLength, .decWide, .decDir, .decRegSel, .decModrm);
    // Feeder trickles bytes in so short-queue refusals and output stalls both occur
    always @(negedge core_clk) begin
        lfsr = step(lfsr);
        exReady = lfsr[0] | lfsr[1];
        if (pending.size() > 0 && lfsr[2]) i_pq.fifo.push_back(pending.pop_front());
    end
    always @(posedge core_clk) begin
        if (!sys_rst && decValid === 1'b1 && exReady === 1'b1) begin
            if (notes.size() == 0) check("spurious", 20'hFFFFF, 20'h00000);
            else begin
                got = {decKind, decLength, decWide, decDir, decRegSel, decModrm};
                check("decode", got, notes.pop_front());
            end
        end
    end
    initial begin
        logic [16:0] seed;
        seed = 17'h174C7;
        sys_rst = 1'b1;
        // Accumulator form keeps bit 1 clear, or it would leave the add-with-carry group
        for (int i = 0; i < 60; i++) begin
            seed = step(step(seed));
            emit(kinds[i % 10], ops[i % 10] | ((i % 10 == 3) ? {6'h00, seed[9:8]} :
                                               (i % 10 == 4) ? {7'h00, seed[8]} : 8'h00),
                 (i % 10 == 5) ? (seed[7:0] & 8'hDF) : seed[7:0]);
        end
        repeat (20) @(posedge core_clk);
        check("reset", {11'h000, decValid, decKind, decLength, decWide}, 20'h00000);
        @(negedge core_clk) sys_rst = 1'b0;
        for (int t = 0; t < 4000 && (notes.size() > 0 || pending.size() > 0); t++) @(posedge core_clk);
        check("leftover", 20'(notes.size()), 20'h00000);
        $display("Test decode_stream done");
        conclude();
    end
    initial begin
        #400000;
        n_mismatch++;
        conclude();
    end
endmodule
